//--- hw/dcsw_pkg.sv
// Purpose: Shared constants and types of the driver control and status word logic.
// Assumes: 100 MHz system clock; serial words are 16 bits, MSB first.
package dcsw_pkg;
	localparam int WORD_W = 16;
	localparam int NUM_SW = 12;
	localparam int CLK_MHZ = 100;
	localparam logic [3:0] CNT_W = 4'hF;
	// Control word fields.
	localparam int CTL_STAT_CLR = 0;
	localparam int CTL_SW_LSB = 1;
	localparam int CTL_OC_LOCK = 13;
	localparam int CTL_UNUSED = 14;
	localparam int CTL_OV_LOCK = 15;
	// Status word fields.
	localparam int ST_TEMP = 0;
	localparam int ST_SW_LSB = 1;
	localparam int ST_OVLD = 13;
	localparam int ST_UNLD = 14;
	localparam int ST_SUPPLY = 15;
	localparam logic [15:0] CTL_RESET = 16'h0000;
	localparam logic [15:0] ST_RESET = 16'h0000;
	// Delays in microseconds and their cycle counts.
	localparam int OC_DELAY_US = 50;
	localparam int UL_BLANK_US = 300;
	localparam int OC_DELAY_CYC = OC_DELAY_US * CLK_MHZ;
	localparam int UL_BLANK_CYC = UL_BLANK_US * CLK_MHZ;
	localparam int TMR_W = 16;

	typedef struct packed {
		logic [NUM_SW-1:0] overcurrent;
		logic [NUM_SW-1:0] underload;
		logic [NUM_SW-1:0] conducting;
		logic temp_warn;
		logic temp_emerg;
		logic temp_recover;
		logic overvoltage;
		logic undervoltage;
	} dcsw_sense_s;

	typedef struct packed {
		logic sclk;
		logic frame_select_low_n;
		logic serial_in;
	} dcsw_link_s;
endpackage : dcsw_pkg

//--- hw/dcsw_sync.sv
// Purpose: Two-flop synchroniser for a bus of asynchronous levels.
// Assumes: Destination clock is sys_clk_i.
// Notes: First stage is read only by the second; reset value is the idle level.
`timescale 1ns/1ns
`default_nettype none
module dcsw_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	// Data
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s1_nxt;
	logic [W-1:0] s2_nxt;

	always_comb begin
		s1_nxt = ce_i ? d_i : s1_r;
		s2_nxt = ce_i ? s1_r : s2_r;
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s1_r <= RST_VAL;
			s2_r <= RST_VAL;
		end else begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
		end
	end

	assign q_o = s2_r;
endmodule : dcsw_sync
`default_nettype wire

//--- hw/dcsw_octimer.sv
// Purpose: Per-channel overcurrent persistence timer.
// Assumes: Overcurrent input already synchronised.
// Notes: Trips once the overcurrent has lasted the full delay.
`timescale 1ns/1ns
`default_nettype none
module dcsw_octimer
	import dcsw_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	// Channel
	input wire logic oc_i,
	output logic trip_o
);
	logic [TMR_W-1:0] cnt_r;
	logic [TMR_W-1:0] cnt_nxt;
	logic trip_nxt;

	always_comb begin
		cnt_nxt = cnt_r;
		trip_nxt = 1'b0;
		if (!oc_i) begin
			cnt_nxt = '0;
		end else if (cnt_r >= TMR_W'(OC_DELAY_CYC - 1)) begin
			trip_nxt = 1'b1;
		end else begin
			cnt_nxt = cnt_r + TMR_W'(1);
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_r <= '0;
			trip_o <= 1'b0;
		end else if (ce_i) begin
			cnt_r <= cnt_nxt;
			trip_o <= trip_nxt;
		end
	end
endmodule : dcsw_octimer
`default_nettype wire

//--- hw/dcsw_top.sv
// Purpose: Serial control word intake, switch drive and latched status word.
// Assumes: Link pins and sense inputs are asynchronous to sys_clk_i.
// Notes: Serial clock is sampled and its edges detected in the system clock.
`timescale 1ns/1ns
`default_nettype none
module dcsw_top
	import dcsw_pkg::*;
(
	// Clock, reset, enable
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	// Serial link
	input wire dcsw_pkg::dcsw_link_s link_i,
	output logic serial_out_o,
	// Supplies and sleep
	input wire logic logic_supply_i,
	input wire logic sleep_inhibit_input_n_i,
	// Analog sense flags
	input wire dcsw_pkg::dcsw_sense_s sense_i,
	// Switch drive: bit k-1 follows control bit k
	output logic [dcsw_pkg::NUM_SW-1:0] switch_on_o,
	output logic [dcsw_pkg::WORD_W-1:0] control_word_o,
	output logic [dcsw_pkg::WORD_W-1:0] status_word_o
);
	import dcsw_pkg::*;

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	localparam int SYNC_W = $bits(dcsw_link_s) + $bits(dcsw_sense_s) + 2;
	// Reset levels equal the idle pins, so leaving reset makes no false select edge.
	localparam logic [SYNC_W-1:0] SYNC_RST = {3'h2, {$bits(dcsw_sense_s){1'b0}}, 2'h1};
	logic [SYNC_W-1:0] sync_q;
	dcsw_link_s lnk;
	dcsw_sense_s sns;
	logic sup_s;
	logic slp_n_s;

	dcsw_sync #(.W(SYNC_W), .RST_VAL(SYNC_RST)) u_sync (
		.sys_clk_i(sys_clk_i),
		.arst_n_i(arst_n_i),
		.ce_i(ce_i),
		.d_i({link_i, sense_i, logic_supply_i, sleep_inhibit_input_n_i}),
		.q_o(sync_q)
	);
	assign {lnk, sns, sup_s, slp_n_s} = sync_q;

	// ----------------------------------------------------------------
	// Overcurrent persistence timers
	// ----------------------------------------------------------------
	logic [NUM_SW-1:0] oc_trip;
	for (genvar g = 0; g < NUM_SW; g++) begin : g_oc
		dcsw_octimer u_oct (
			.sys_clk_i(sys_clk_i),
			.arst_n_i(arst_n_i),
			.ce_i(ce_i),
			.oc_i(sns.overcurrent[g]),
			.trip_o(oc_trip[g])
		);
	end

	// ----------------------------------------------------------------
	// Serial shifter
	// ----------------------------------------------------------------
	logic sclk_d_r, sclk_d_nxt;
	logic sel_d_r, sel_d_nxt;
	logic [WORD_W-1:0] shin_r, shin_nxt;
	logic [WORD_W-1:0] shout_r, shout_nxt;
	logic [WORD_W-1:0] ctl_r, ctl_nxt;
	logic [WORD_W-1:0] st_r, st_nxt;
	logic [NUM_SW-1:0] lock_r, lock_nxt;
	logic [TMR_W-1:0] blank_r, blank_nxt;
	logic sup_d_r, sup_d_nxt;
	logic sdo_r, sdo_nxt;
	logic [NUM_SW-1:0] sw_r, sw_nxt;
	logic sclk_rise, sclk_fall, cs_fall, cs_rise, active;

	assign sclk_rise = lnk.sclk & ~sclk_d_r;
	assign sclk_fall = ~lnk.sclk & sclk_d_r;
	assign cs_fall = ~lnk.frame_select_low_n & sel_d_r;
	assign cs_rise = lnk.frame_select_low_n & ~sel_d_r;
	assign active = ~lnk.frame_select_low_n;

	always_comb begin
		sclk_d_nxt = lnk.sclk;
		sel_d_nxt = lnk.frame_select_low_n;
		shin_nxt = shin_r;
		shout_nxt = shout_r;
		sdo_nxt = sdo_r;
		ctl_nxt = ctl_r;
		if (cs_fall) begin
			shout_nxt = st_r;
			sdo_nxt = st_r[WORD_W-1];
		end else if (active && sclk_rise) begin
			shin_nxt = {shin_r[WORD_W-2:0], lnk.serial_in};
		end else if (active && sclk_fall) begin
			shout_nxt = {shout_r[WORD_W-2:0], 1'b0};
			sdo_nxt = shout_r[WORD_W-2];
		end
		if (cs_rise) begin
			ctl_nxt = shin_r;
		end
	end

	// ----------------------------------------------------------------
	// Protection and switch drive
	// ----------------------------------------------------------------
	logic all_off;
	always_comb begin
		lock_nxt = lock_r;
		if (cs_rise) begin
			lock_nxt = '0;
		end
		if (ctl_r[CTL_OC_LOCK]) begin
			lock_nxt = lock_nxt | oc_trip;
		end
		all_off = sns.temp_emerg
			| (ctl_r[CTL_OV_LOCK] & sns.overvoltage);
		sw_nxt = all_off ? '0 : (ctl_r[CTL_SW_LSB +: NUM_SW] & ~lock_r);
		blank_nxt = blank_r;
		if (cs_rise) begin
			blank_nxt = TMR_W'(UL_BLANK_CYC);
		end else if (blank_r != '0) begin
			blank_nxt = blank_r - TMR_W'(1);
		end
	end

	// ----------------------------------------------------------------
	// Status word
	// ----------------------------------------------------------------
	always_comb begin
		sup_d_nxt = sup_s;
		st_nxt = st_r;
		st_nxt[ST_SW_LSB +: NUM_SW] = sns.conducting;
		if (!slp_n_s) begin
			st_nxt = ST_RESET;
		end else begin
			// A supply change clears the flags like bit 0 does; a same-cycle set still wins.
			if ((cs_rise && ctl_r[CTL_STAT_CLR]) || sup_s != sup_d_r) begin
				st_nxt[ST_OVLD] = 1'b0;
				st_nxt[ST_UNLD] = 1'b0;
				st_nxt[ST_SUPPLY] = 1'b0;
				st_nxt[ST_TEMP] = 1'b0;
			end
			if (sns.temp_warn) begin
				st_nxt[ST_TEMP] = 1'b1;
			end else if (sns.temp_recover) begin
				st_nxt[ST_TEMP] = 1'b0;
			end
			if (ctl_r[CTL_OC_LOCK] && |oc_trip) begin
				st_nxt[ST_OVLD] = 1'b1;
			end
			if (blank_r == '0 && !cs_rise && |sns.underload) begin
				st_nxt[ST_UNLD] = 1'b1;
			end
			if (sns.overvoltage || sns.undervoltage) begin
				st_nxt[ST_SUPPLY] = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sclk_d_r <= 1'b0;
			sel_d_r <= 1'b1;
			shin_r <= '0;
			shout_r <= '0;
			sdo_r <= 1'b0;
			ctl_r <= CTL_RESET;
			st_r <= ST_RESET;
			lock_r <= '0;
			blank_r <= '0;
			sup_d_r <= 1'b0;
			sw_r <= '0;
		end else if (ce_i) begin
			sclk_d_r <= sclk_d_nxt;
			sel_d_r <= sel_d_nxt;
			shin_r <= shin_nxt;
			shout_r <= shout_nxt;
			sdo_r <= sdo_nxt;
			ctl_r <= ctl_nxt;
			st_r <= st_nxt;
			lock_r <= lock_nxt;
			blank_r <= blank_nxt;
			sup_d_r <= sup_d_nxt;
			sw_r <= sw_nxt;
		end
	end

	assign serial_out_o = sdo_r;
	assign switch_on_o = sw_r;
	assign control_word_o = ctl_r;
	assign status_word_o = st_r;
endmodule : dcsw_top
`default_nettype wire

//--- testbench/dcsw_chk.sv
// Purpose: Port-level assertions on the control and status word logic.
// Assumes: Clock enable lows only freeze state; the live-state check waits for it.
// Notes: Sense inputs pass two sync flops, hence the repeat counts.
`timescale 1ns/1ns
`default_nettype none
module dcsw_chk
	import dcsw_pkg::*;
(
	// Clock, reset, enable
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	// Watched ports
	input wire dcsw_pkg::dcsw_link_s link_i,
	input wire logic serial_out_o,
	input wire logic logic_supply_i,
	input wire logic sleep_inhibit_input_n_i,
	input wire dcsw_pkg::dcsw_sense_s sense_i,
	input wire logic [dcsw_pkg::NUM_SW-1:0] switch_on_o,
	input wire logic [dcsw_pkg::WORD_W-1:0] control_word_o,
	input wire logic [dcsw_pkg::WORD_W-1:0] status_word_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!arst_n_i);
	chk_emerg_off: assert property (sense_i.temp_emerg [*6] |-> switch_on_o == '0)
		else $error("outputs on in emergency");
	chk_ov_shutoff: assert property ((control_word_o[15] && sense_i.overvoltage) [*6]
		|-> switch_on_o == '0) else $error("outputs on in overvoltage");
	chk_sw_follow: assert property ($changed(control_word_o) && !sense_i.temp_emerg
		&& !sense_i.overvoltage && sense_i.overcurrent == '0
		|=> switch_on_o == control_word_o[12:1]) else $error("switch map");
	chk_ctl_frame: assert property ($changed(control_word_o)
		|-> $past(link_i.frame_select_low_n, 2)) else $error("control changed in frame");
	chk_temp_set: assert property ((sense_i.temp_warn && sleep_inhibit_input_n_i) [*5]
		|-> status_word_o[0]) else $error("warning not set");
	chk_temp_clear: assert property ((sense_i.temp_recover && !sense_i.temp_warn) [*5]
		|-> !status_word_o[0]) else $error("warning not cleared");
	chk_live_state: assert property (($stable(sense_i.conducting) &&
		ce_i && sleep_inhibit_input_n_i && $stable(logic_supply_i)) [*6]
		|-> status_word_o[12:1] == sense_i.conducting) else $error("switch state");
	chk_flags_held: assert property (status_word_o[15:13] != 3'h0 &&
		!control_word_o[0] && sleep_inhibit_input_n_i && $past(sleep_inhibit_input_n_i, 5)
		&& logic_supply_i == $past(logic_supply_i, 5)
		|=> (status_word_o[15:13] & $past(status_word_o[15:13])) ==
		$past(status_word_o[15:13])) else $error("flag lost");
endmodule : dcsw_chk
bind dcsw_top dcsw_chk u_chk (.sys_clk_i, .arst_n_i, .ce_i, .link_i, .serial_out_o,
	.logic_supply_i, .sleep_inhibit_input_n_i, .sense_i, .switch_on_o, .control_word_o,
	.status_word_o);
`default_nettype wire

//--- testbench/dcsw_host.sv
// Purpose: Serial master model that sends a control word and reads status.
// Assumes: 80 ns serial clock, idle low between frames.
// Notes: Data is sampled just before each falling clock edge.
`timescale 1ns/1ns
`default_nettype none
module dcsw_host
	import dcsw_pkg::*;
(
	// Link
	output var dcsw_pkg::dcsw_link_s link_o,
	input wire logic serial_out_i
);
	initial link_o = 3'h2;
	task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
		#3 link_o.frame_select_low_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			link_o.serial_in = tx[i];
			#40 link_o.sclk = 1'b1;
			#40 rx[i] = serial_out_i;
			link_o.sclk = 1'b0;
		end
		#40 link_o.frame_select_low_n = 1'b1;
		link_o.serial_in = ~tx[0];
	endtask : xfer
endmodule : dcsw_host
`default_nettype wire

//--- testbench/testbench.sv
// Purpose: Frame-level tests of the control and status word logic.
// Assumes: Host model drives the link; sense inputs change on falling edges.
// Notes: Full-length delay constants are used.
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import dcsw_pkg::*;
	logic sys_clk_i, arst_n_i, sup, slp_n, so, ce;
	logic [11:0] sw;
	logic [15:0] ctl, st, rx;
	dcsw_link_s lnk;
	dcsw_sense_s sn;
	int miscompares = 0;
	int samples_checked = 0;
	dcsw_top uut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .ce_i(ce), .link_i(lnk),
		.serial_out_o(so), .logic_supply_i(sup), .sleep_inhibit_input_n_i(slp_n),
		.sense_i(sn), .switch_on_o(sw), .control_word_o(ctl), .status_word_o(st));
	dcsw_host host (.link_o(lnk), .serial_out_i(so));
	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	task automatic w(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask : w
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic send(input logic [15:0] word);
		host.xfer(word, rx);
		w(8);
	endtask : send
	task automatic tally_and_finish;
		if (miscompares == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		arst_n_i = 1'b0;
		sup = 1'b0;
		slp_n = 1'b1;
		ce = 1'b1;
		sn = '0;
		w(8);
		arst_n_i = 1'b1;
		w(4);
		chk(st, ST_RESET);
		send(16'h5554);
		chk(ctl, 16'h5554);
		chk(16'(sw), 16'h0AAA);
		sn.conducting = 12'hA5C;
		w(8);
		chk(16'(st[12:1]), 16'h0A5C);
		ce = 1'b0;
		sn.conducting = 12'h123;
		w(8);
		chk(16'(st[12:1]), 16'h0A5C);
		ce = 1'b1;
		w(8);
		chk(16'(st[12:1]), 16'h0123);
		sn.conducting = 12'hA5C;
		w(8);
		send(16'h800A);
		chk(16'(rx[12:1]), 16'h0A5C);
		sn.overvoltage = 1'b1;
		w(8);
		chk(16'(sw), 16'h0000);
		sn.overvoltage = 1'b0;
		w(8);
		chk(16'(st[15]), 16'h0001);
		slp_n = 1'b0;
		w(8);
		chk(16'(st[15]), 16'h0000);
		slp_n = 1'b1;
		send(16'h000A);
		sn.overvoltage = 1'b1;
		w(8);
		chk(16'(sw), 16'h0005);
		chk(16'(st[15]), 16'h0001);
		sn.overvoltage = 1'b0;
		sup = 1'b1;
		w(8);
		chk(16'(st[15]), 16'h0000);
		sn.temp_warn = 1'b1;
		w(8);
		sn.temp_warn = 1'b0;
		sn.temp_emerg = 1'b1;
		w(8);
		chk(16'(sw), 16'h0000);
		chk(ctl, 16'h000A);
		chk(16'(st[0]), 16'h0001);
		sn.temp_emerg = 1'b0;
		sn.temp_recover = 1'b1;
		w(8);
		chk(16'(st[0]), 16'h0000);
		sn.temp_recover = 1'b0;
		sn.undervoltage = 1'b1;
		w(8);
		sn.undervoltage = 1'b0;
		w(8);
		chk(16'(st[15]), 16'h0001);
		send(16'h2002);
		sn.overcurrent = 12'h001;
		w(OC_DELAY_CYC - 100);
		chk(16'(sw), 16'h0001);
		w(200);
		chk(16'(sw), 16'h0000);
		sn.overcurrent = 12'h000;
		w(8);
		chk(16'(st[13]), 16'h0001);
		send(16'h0002);
		sn.overcurrent = 12'h001;
		w(OC_DELAY_CYC + 200);
		chk(16'(sw), 16'h0001);
		sn.overcurrent = 12'h000;
		send(16'h0003);
		chk(16'(st[13]), 16'h0001);
		chk(rx, 16'hB4B8);
		send(16'h0002);
		chk(16'(st[13]), 16'h0000);
		sn.underload = 12'h001;
		w(100);
		chk(16'(st[14]), 16'h0000);
		sn.underload = 12'h000;
		w(UL_BLANK_CYC);
		sn.underload = 12'h001;
		w(8);
		chk(16'(st[14]), 16'h0001);
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
